/* File: pkg/rism_defs.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 reference input status monitor. Offsets are word indices: the bus byte
 address is four times the offset. Assumes inclusion by its bare name.
*/
`ifndef RISM_DEFS_SVH
`define RISM_DEFS_SVH
`define RISM_OFS_STAT_B      16'h3007
`define RISM_OFS_STAT_BB     16'h3008
`define RISM_OFS_STAT_AA     16'h3006
`define RISM_OFS_XFER        16'h3100
`define RISM_OFS_IRQ_STAT    16'h3104
`define RISM_OFS_IRQ_CLR     16'h3108
`define RISM_OFS_IRQ_EN      16'h310C
`define RISM_OFS_VALID_TIME  16'h3110
`define RISM_BIT_SLOW        0
`define RISM_BIT_FAST        1
`define RISM_BIT_JITTER      2
`define RISM_BIT_FAULT       3
`define RISM_BIT_VALID       4
`define RISM_BIT_LOS         5
`define RISM_STAT_RST        8'h00
`define RISM_VALID_TIME_RST  16'h0010
`define RISM_NUM_IN          3
`endif

/* File: pkg/rism_pkg.sv */
/*
 Types of the reference input status monitor.
 Assumes rism_defs.svh is available on the include path.
*/
package rism_pkg;
   // Live raw indications of one reference input
   typedef struct packed
   {
      logic los;
      logic in_window;
      logic jitter_high;
      logic fast;
      logic slow;
   } rism_raw_s;
   typedef logic [7:0] rism_stat_t;
   typedef enum logic [1:0] {RISM_RD_IDLE, RISM_RD_RESP} rism_rd_e;
   typedef enum logic [1:0] {RISM_WR_IDLE, RISM_WR_RESP} rism_wr_e;
endpackage

/* File: design/rism_top.sv */
/*
 Reference input status monitor: per input live status, validation timer,
 transfer-strobe buffering, sticky fault interrupts and an AXI4-Lite slave.
 Assumes raw indications come from pins/other domains and need two flops.
*/
// Functional notes
// - input B loss sets status bit 5
// - fault bit high while input faulted
// - valid only after window held timer long
// - input B fault ORs los fast slow jitter
// - input B jitter exceeded sets bit 2
// - input B above limit sets bit 1
// - input B below limit sets bit 0
// - fast and slow may both be set
// - readable status updates only on transfer strobe
// - input BB register, loss at bit 5
// - input BB valid after timer in window
// - input BB fault ORs its four indications
// - input BB jitter exceeded sets bit 2
// - input AA below limit sets bit 0
// - fast bits at bit 1, BB too
`timescale 1ns/10ps
`include "rism_defs.svh"
module rism_top
(
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire rism_pkg::rism_raw_s raw_b,
   input  wire rism_pkg::rism_raw_s raw_bb,
   input  wire rism_pkg::rism_raw_s raw_aa,
   input  wire logic [15:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [15:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     irq
);
   localparam int NI = `RISM_NUM_IN;
   ////////////////////////////////////////////////////////////////////////
   rism_pkg::rism_raw_s       raw_in [NI];
   rism_pkg::rism_raw_s       sync1_ff [NI];
   rism_pkg::rism_raw_s       sync2_ff [NI];
   logic [15:0]               vcnt_ff [NI];
   logic [NI-1:0]             valid_ff;
   rism_pkg::rism_stat_t      live [NI];
   rism_pkg::rism_stat_t      shadow_ff [NI];
   logic [NI-1:0]             fault_prev_ff;
   logic [NI-1:0]             irq_stat_ff;
   logic [NI-1:0]             irq_en_ff;
   logic [15:0]               valid_time_ff;
   logic                      xfer_pulse;
   logic [NI-1:0]             irq_clr;
   logic [NI-1:0]             fault_rise;
   rism_pkg::rism_wr_e        wr_state_ff;
   rism_pkg::rism_rd_e        rd_state_ff;
   logic [15:0]               awaddr_ff;
   logic [31:0]               wdata_ff;
   logic [3:0]                wstrb_ff;
   logic                      aw_have_ff;
   logic                      w_have_ff;
   logic                      wr_do;
   logic [31:0]               nxt_rdata;
   logic [1:0]                nxt_rresp;

   assign raw_in[0] = raw_b;
   assign raw_in[1] = raw_bb;
   assign raw_in[2] = raw_aa;

   ////////////////////////////////////////////////////////////////////////
   // Per input: synchroniser, validation timer and live status byte
   generate
      for (genvar i = 0; i < NI; i++)
      begin : g_in
         // Two flops; nothing reads the first one but the second
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               sync1_ff[i] <= '0;
               sync2_ff[i] <= '0;
            end
            else
            begin
               sync1_ff[i] <= raw_in[i];
               sync2_ff[i] <= sync1_ff[i];
            end
         end

         // Valid needs the period in window for the whole timer span
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               vcnt_ff[i]  <= '0;
               valid_ff[i] <= 1'b0;
            end
            else if (!sync2_ff[i].in_window || sync2_ff[i].los)
            begin
               vcnt_ff[i]  <= '0;
               valid_ff[i] <= 1'b0;
            end
            else if (vcnt_ff[i] >= valid_time_ff)
            begin
               valid_ff[i] <= 1'b1;
            end
            else
            begin
               vcnt_ff[i] <= vcnt_ff[i] + 16'h0001;
            end
         end

         // Fast and slow pass independently, so both may be high together
         always_comb
         begin
            live[i] = `RISM_STAT_RST;
            live[i][`RISM_BIT_LOS]    = sync2_ff[i].los;
            live[i][`RISM_BIT_VALID]  = valid_ff[i];
            live[i][`RISM_BIT_JITTER] = sync2_ff[i].jitter_high;
            live[i][`RISM_BIT_FAST]   = sync2_ff[i].fast;
            live[i][`RISM_BIT_SLOW]   = sync2_ff[i].slow;
            live[i][`RISM_BIT_FAULT]  = sync2_ff[i].los | sync2_ff[i].fast
                                      | sync2_ff[i].slow
                                      | sync2_ff[i].jitter_high;
         end

         // Readable copy moves only on the transfer strobe
         always_ff @(posedge clk)
         begin
            if (reset)
               shadow_ff[i] <= `RISM_STAT_RST;
            else if (xfer_pulse)
               shadow_ff[i] <= live[i];
         end

         // Sticky fault interrupt: a new rise beats a same-cycle clear
         assign fault_rise[i] = live[i][`RISM_BIT_FAULT] & ~fault_prev_ff[i];
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               fault_prev_ff[i] <= 1'b0;
               irq_stat_ff[i]   <= 1'b0;
            end
            else
            begin
               fault_prev_ff[i] <= live[i][`RISM_BIT_FAULT];
               if (fault_rise[i])
                  irq_stat_ff[i] <= 1'b1;
               else if (irq_clr[i])
                  irq_stat_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq = |(irq_stat_ff & irq_en_ff);

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   assign s_axi_awready = (wr_state_ff == rism_pkg::RISM_WR_IDLE) && !aw_have_ff;
   assign s_axi_wready  = (wr_state_ff == rism_pkg::RISM_WR_IDLE) && !w_have_ff;
   assign wr_do = (wr_state_ff == rism_pkg::RISM_WR_IDLE)
                && (aw_have_ff || s_axi_awvalid) && (w_have_ff || s_axi_wvalid);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
      end
      else if (wr_do)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
      end
   end

   // Effective write beat, whichever channel arrived last
   logic [15:0] wr_addr;
   logic [31:0] wr_data;
   logic        wr_lane0;
   assign wr_addr  = aw_have_ff ? awaddr_ff : s_axi_awaddr;
   assign wr_data  = w_have_ff ? wdata_ff : s_axi_wdata;
   assign wr_lane0 = w_have_ff ? wstrb_ff[0] : s_axi_wstrb[0];

   // Command decode; status registers take no writes at all
   always_comb
   begin
      xfer_pulse = 1'b0;
      irq_clr    = '0;
      if (wr_do && wr_addr[15:2] == 14'(`RISM_OFS_XFER))
         xfer_pulse = wr_lane0 & wr_data[0];
      else if (wr_do && wr_addr[15:2] == 14'(`RISM_OFS_IRQ_CLR))
         irq_clr = wr_lane0 ? wr_data[NI-1:0] : '0;
   end

   // Control registers; writes to status offsets fall through unheeded
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq_en_ff     <= '0;
         valid_time_ff <= `RISM_VALID_TIME_RST;
      end
      else if (wr_do && wr_addr[15:2] == 14'(`RISM_OFS_IRQ_EN))
      begin
         if (wr_lane0)
            irq_en_ff <= wr_data[NI-1:0];
      end
      else if (wr_do && wr_addr[15:2] == 14'(`RISM_OFS_VALID_TIME))
      begin
         if (wr_lane0)
            valid_time_ff[7:0] <= wr_data[7:0];
         if (w_have_ff ? wstrb_ff[1] : s_axi_wstrb[1])
            valid_time_ff[15:8] <= wr_data[15:8];
      end
   end

   // Write response: OKAY everywhere, status writes simply dropped
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_state_ff  <= rism_pkg::RISM_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else
      begin
         case (wr_state_ff)
            rism_pkg::RISM_WR_IDLE:
               if (wr_do)
               begin
                  wr_state_ff  <= rism_pkg::RISM_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= 2'h0;
               end
            default:
               if (s_axi_bready)
               begin
                  wr_state_ff  <= rism_pkg::RISM_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped addresses answer SLVERR with zero data
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = 2'h0;
      // Word index sits in address bits 15:2; the low two bits are ignored
      if (s_axi_araddr[15:2] == 14'(`RISM_OFS_STAT_B))
         nxt_rdata = {24'h000000, shadow_ff[0]};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_STAT_BB))
         nxt_rdata = {24'h000000, shadow_ff[1]};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_STAT_AA))
         nxt_rdata = {24'h000000, shadow_ff[2]};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_IRQ_STAT))
         nxt_rdata = {29'h0, irq_stat_ff};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_IRQ_EN))
         nxt_rdata = {29'h0, irq_en_ff};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_VALID_TIME))
         nxt_rdata = {16'h0000, valid_time_ff};
      else if (s_axi_araddr[15:2] == 14'(`RISM_OFS_XFER)
               || s_axi_araddr[15:2] == 14'(`RISM_OFS_IRQ_CLR))
         nxt_rdata = 32'h0000_0000;
      else
         nxt_rresp = 2'h2;
   end

   assign s_axi_arready = (rd_state_ff == rism_pkg::RISM_RD_IDLE);

   // Read response held until rready
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rd_state_ff  <= rism_pkg::RISM_RD_IDLE;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= 2'h0;
      end
      else
      begin
         case (rd_state_ff)
            rism_pkg::RISM_RD_IDLE:
               if (s_axi_arvalid)
               begin
                  rd_state_ff  <= rism_pkg::RISM_RD_RESP;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata  <= nxt_rdata;
                  s_axi_rresp  <= nxt_rresp;
               end
            default:
               if (s_axi_rready)
               begin
                  rd_state_ff  <= rism_pkg::RISM_RD_IDLE;
                  s_axi_rvalid <= 1'b0;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_fault_is_or: assert property (@(posedge clk) disable iff (reset)
      live[0][`RISM_BIT_FAULT] == (|{live[0][5], live[0][2:0]}))
      else $error("input B fault is not the OR of its indications");
   a_bb_fault_or: assert property (@(posedge clk) disable iff (reset)
      live[1][`RISM_BIT_FAULT] == (|{live[1][5], live[1][2:0]}))
      else $error("input BB fault is not the OR of its indications");
   a_fault_covers_los: assert property (@(posedge clk) disable iff (reset)
      xfer_pulse && live[0][`RISM_BIT_LOS] |=> shadow_ff[0][`RISM_BIT_FAULT])
      else $error("fault low while loss reported");
   a_shadow_hold: assert property (@(posedge clk) disable iff (reset)
      !$past(xfer_pulse) && !$past(reset) |-> $stable(shadow_ff[0]))
      else $error("readable status moved without strobe");
   a_shadow_load: assert property (@(posedge clk) disable iff (reset)
      xfer_pulse |=> shadow_ff[1] == $past(live[1]))
      else $error("strobe did not load live status");
   a_los_bit_b: assert property (@(posedge clk) disable iff (reset)
      xfer_pulse |=> shadow_ff[0][`RISM_BIT_LOS] == $past(sync2_ff[0].los))
      else $error("input B loss not shown");
   a_valid_needs_win: assert property (@(posedge clk) disable iff (reset)
      !sync2_ff[0].in_window |=> !valid_ff[0])
      else $error("input B valid without window");
   a_bb_valid_win: assert property (@(posedge clk) disable iff (reset)
      $rose(valid_ff[1]) |-> $past(sync2_ff[1].in_window, 2))
      else $error("input BB valid rose too early");
   a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
      shadow_ff[0][7:6] == 2'h0 && shadow_ff[1][7:6] == 2'h0)
      else $error("reserved status bits not zero");
   a_jitter_b: assert property (@(posedge clk) disable iff (reset)
      !$past(reset) && !$past(reset, 2)
      |-> live[0][`RISM_BIT_JITTER] == $past(raw_b.jitter_high, 2))
      else $error("input B jitter bit wrong");
   a_aa_slow: assert property (@(posedge clk) disable iff (reset)
      xfer_pulse |=> shadow_ff[2][`RISM_BIT_SLOW] == $past(sync2_ff[2].slow))
      else $error("input AA slow not shown");
endmodule

/* File: test/rism_ref_src.sv */
/*
 Model of the reference clock sources: turns a condition code per input into
 live raw indications. Assumes codes change just after a clock edge.
*/
`timescale 1ns/10ps
module rism_ref_src
(
   input  wire logic           clk,
   input  wire logic [2:0]     cond_b,
   input  wire logic [2:0]     cond_bb,
   input  wire logic [2:0]     cond_aa,
   output rism_pkg::rism_raw_s raw_b,
   output rism_pkg::rism_raw_s raw_bb,
   output rism_pkg::rism_raw_s raw_aa
);
   // Codes: 0 healthy, 1 missing, 2 fast, 3 slow, 4 jittery, 5 off period, 7 quiet
   function automatic rism_pkg::rism_raw_s to_raw(input logic [2:0] c);
      rism_pkg::rism_raw_s r;
      r.los = (c == 3'h1);
      r.fast = (c == 3'h1) || (c == 3'h2);
      r.slow = (c == 3'h1) || (c == 3'h3);
      r.jitter_high = (c == 3'h4);
      r.in_window = (c == 3'h0) || (c == 3'h4);
      return r;
   endfunction

   // Indications move only after an edge, like a real detector output
   always_ff @(posedge clk)
   begin
      raw_b <= to_raw(cond_b);
      raw_bb <= to_raw(cond_bb);
      raw_aa <= to_raw(cond_aa);
   end
endmodule

/* File: test/tb_top.sv */
/*
 Self-checking bench of the status monitor: register bus tasks, source
 conditions per input, read-back compares. Assumes design and model compiled.
*/
`timescale 1ns/10ps
`include "rism_defs.svh"
module tb_top;
   logic                clk, reset, irq;
   rism_pkg::rism_raw_s raw_b, raw_bb, raw_aa;
   logic [2:0]          cond_b, cond_bb, cond_aa;
   logic [15:0]         awaddr, araddr;
   logic [31:0]         wdata, rdata, rd_q;
   logic                awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic                bready, rready;
   logic [1:0]          bresp, rresp, rresp_q;
   int                  error_cnt, compares;

   rism_top dut
   (
      .clk(clk), .reset(reset), .raw_b(raw_b), .raw_bb(raw_bb), .raw_aa(raw_aa),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
   );
   rism_ref_src src
   (
      .clk(clk), .cond_b(cond_b), .cond_bb(cond_bb), .cond_aa(cond_aa),
      .raw_b(raw_b), .raw_bb(raw_bb), .raw_aa(raw_aa)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Wait for ready or response; look just after the edge, taken at the next one
   task automatic hs(input int k);
      logic ok;
      int   n;
      ok = 1'b0;
      n = 0;
      while (!ok && n < 200)
      begin
         #1;
         ok = (k == 0) ? arready : (k == 1) ? rvalid : bvalid;
         rd_q = rdata;
         rresp_q = rresp;
         @(posedge clk);
         n++;
      end
      if (!ok)
         chk(32'h0, 32'h1);
   endtask

   // Register offsets are word indices; the bus carries byte addresses
   function automatic logic [15:0] ba(input logic [15:0] idx);
      return {idx[13:0], 2'h0};
   endfunction

   // Address and data offered together, each released once taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic aw_p, w_p, aw_t, w_t;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= ba(a);
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw_p || w_p)
      begin
         #1;
         aw_t = aw_p && awready;
         w_t = w_p && wready;
         @(posedge clk);
         if (aw_t) aw_p = 1'b0;
         if (w_t) w_p = 1'b0;
         awvalid <= aw_p;
         wvalid <= w_p;
      end
      bready <= 1'b1;
      hs(2);
      bready <= 1'b0;
      chk({30'h0, bresp}, 32'h0);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= ba(a);
      arvalid <= 1'b1;
      hs(0);
      arvalid <= 1'b0;
      rready <= 1'b1;
      hs(1);
      rready <= 1'b0;
      chk(rd_q, ed);
      chk({30'h0, rresp_q}, {30'h0, er});
   endtask

   task automatic setc(input logic [2:0] b, input logic [2:0] bb, input logic [2:0] aa);
      cond_b <= b;
      cond_bb <= bb;
      cond_aa <= aa;
      repeat (20) @(posedge clk);
   endtask

   // Settled status for a held condition; a missing clock is never valid
   function automatic logic [31:0] exp_stat(input logic [2:0] c);
      logic l, f, s, j, w;
      l = (c == 3'h1);
      f = l || (c == 3'h2);
      s = l || (c == 3'h3);
      j = (c == 3'h4);
      w = (c == 3'h0) || j;
      return {26'h0, l, w && !l, l || f || s || j, j, f, s};
   endfunction

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      reset = 1'b1;
      {awvalid, wvalid, arvalid, bready, rready} = 5'h0;
      {awaddr, araddr, wdata} = '0;
      {cond_b, cond_bb, cond_aa} = 9'h1FF;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(`RISM_OFS_STAT_B, 32'h0, 2'h0);
      rd_chk(`RISM_OFS_STAT_BB, 32'h0, 2'h0);
      chk({31'h0, irq}, 32'h0);
      // Short timer; valid must not show before it runs out
      wr(`RISM_OFS_VALID_TIME, 32'h8);
      cond_b <= 3'h0;
      cond_bb <= 3'h0;
      repeat (3) @(posedge clk);
      wr(`RISM_OFS_XFER, 32'h1);
      rd_chk(`RISM_OFS_STAT_B, 32'h0, 2'h0);
      rd_chk(`RISM_OFS_STAT_BB, 32'h0, 2'h0);
      setc(3'h0, 3'h0, 3'h0);
      wr(`RISM_OFS_XFER, 32'h1);
      rd_chk(`RISM_OFS_STAT_B, 32'h10, 2'h0);
      rd_chk(`RISM_OFS_STAT_BB, 32'h10, 2'h0);
      // Every fault condition on every input
      for (int m = 1; m < 6; m++)
      begin
         setc(m[2:0], m[2:0], m[2:0]);
         wr(`RISM_OFS_XFER, 32'h1);
         rd_chk(`RISM_OFS_STAT_B, exp_stat(m[2:0]), 2'h0);
         rd_chk(`RISM_OFS_STAT_BB, exp_stat(m[2:0]), 2'h0);
         rd_chk(`RISM_OFS_STAT_AA, exp_stat(m[2:0]), 2'h0);
      end
      // Buffered view holds until the strobe
      setc(3'h0, 3'h0, 3'h0);
      rd_chk(`RISM_OFS_STAT_B, 32'h0, 2'h0);
      wr(`RISM_OFS_XFER, 32'h1);
      rd_chk(`RISM_OFS_STAT_B, 32'h10, 2'h0);
      wr(`RISM_OFS_STAT_B, 32'hFF);
      wr(`RISM_OFS_XFER, 32'h1);
      rd_chk(`RISM_OFS_STAT_B, 32'h10, 2'h0);
      rd_chk(16'h3200, 32'h0, 2'h2);
      // Sticky fault events, mask and clear
      wr(`RISM_OFS_IRQ_CLR, 32'h7);
      rd_chk(`RISM_OFS_IRQ_STAT, 32'h0, 2'h0);
      wr(`RISM_OFS_IRQ_EN, 32'h1);
      setc(3'h1, 3'h1, 3'h0);
      rd_chk(`RISM_OFS_IRQ_STAT, 32'h3, 2'h0);
      chk({31'h0, irq}, 32'h1);
      wr(`RISM_OFS_IRQ_CLR, 32'h1);
      rd_chk(`RISM_OFS_IRQ_STAT, 32'h2, 2'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`RISM_OFS_IRQ_EN, 32'h2);
      rd_chk(`RISM_OFS_IRQ_EN, 32'h2, 2'h0);
      chk({31'h0, irq}, 32'h1);
      wr(`RISM_OFS_IRQ_CLR, 32'h2);
      chk({31'h0, irq}, 32'h0);
      // Read answer and its data stand while rready is held off
      araddr <= ba(`RISM_OFS_VALID_TIME);
      arvalid <= 1'b1;
      hs(0);
      arvalid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, 32'h8);
      @(posedge clk);
      rready <= 1'b1;
      hs(1);
      rready <= 1'b0;
      chk(rd_q, 32'h8);
      // Mid-run reset brings control and readable status back to reset values
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`RISM_OFS_VALID_TIME, {16'h0000, `RISM_VALID_TIME_RST}, 2'h0);
      rd_chk(`RISM_OFS_IRQ_EN, 32'h0, 2'h0);
      rd_chk(`RISM_OFS_STAT_B, 32'h0, 2'h0);
      finish_test();
   end
endmodule
